// ===== common/dt_pkg.sv
// Shared constants, register map and types for the dual 16/32-bit timer
package dt_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [9:0] DT_IDX_LOWER_COUNT   = 10'h106;
    localparam logic [9:0] DT_IDX_UPPER_HOLD    = 10'h108;
    localparam logic [9:0] DT_IDX_UPPER_COUNT   = 10'h10a;
    localparam logic [9:0] DT_IDX_LOWER_PERIOD  = 10'h10c;
    localparam logic [9:0] DT_IDX_UPPER_PERIOD  = 10'h10e;
    localparam logic [9:0] DT_IDX_LOWER_CONTROL = 10'h110;
    localparam logic [9:0] DT_IDX_UPPER_CONTROL = 10'h112;
    localparam logic [9:0] DT_IDX_IRQ_FLAG      = 10'h114;
    localparam logic [9:0] DT_IDX_IRQ_ENABLE    = 10'h116;

    localparam int DT_ADDR_W = 12;
    localparam int DT_DATA_W = 16;

    // Values after reset
    localparam logic [15:0] DT_RST_COUNT   = 16'h0000;
    localparam logic [15:0] DT_RST_PERIOD  = 16'hffff;
    localparam logic [15:0] DT_RST_CONTROL = 16'h0000;
    localparam logic [15:0] DT_RST_IRQ     = 16'h0000;
    localparam logic [7:0]  DT_RST_PS      = 8'h00;

    // Interrupt flag and enable bit positions
    localparam int DT_BIT_IRQ_UPPER = 7;
    localparam int DT_BIT_IRQ_LOWER = 6;
    localparam logic [15:0] DT_IRQ_MASK = 16'h00c0;

    // Prescale select encodings and terminal counts
    localparam logic [1:0] DT_PS_1   = 2'h0;
    localparam logic [1:0] DT_PS_8   = 2'h1;
    localparam logic [1:0] DT_PS_64  = 2'h2;
    localparam logic [1:0] DT_PS_256 = 2'h3;
    localparam logic [7:0] DT_PS_LIM_1   = 8'h00;
    localparam logic [7:0] DT_PS_LIM_8   = 8'h07;
    localparam logic [7:0] DT_PS_LIM_64  = 8'h3f;
    localparam logic [7:0] DT_PS_LIM_256 = 8'hff;

    // Control register layout, bit 15 down to bit 0
    typedef struct packed {
        logic       timer_on;            // 15
        logic       rsv14;               // 14
        logic       idle_stop;           // 13
        logic [5:0] rsv12_7;             // 12..7
        logic       gate_enable;         // 6
        logic [1:0] prescale_select;     // 5..4
        logic       wide_mode_select;    // 3
        logic       rsv2;                // 2
        logic       clock_source_select; // 1
        logic       rsv0;                // 0
    } dt_ctrl_t;

    // Keep only implemented bits; the upper control has no wide mode bit
    function automatic dt_ctrl_t dt_ctrl_mask(input logic [15:0] d, input logic is_lower);
        dt_ctrl_t c;
        c = dt_ctrl_t'(d);
        c.rsv14 = 1'b0;
        c.rsv12_7 = 6'h00;
        c.rsv2 = 1'b0;
        c.rsv0 = 1'b0;
        c.wide_mode_select = d[3] & is_lower;
        return c;
    endfunction

    // Terminal count of the prescaler for a select value
    function automatic logic [7:0] dt_ps_limit(input logic [1:0] sel);
        logic [7:0] lim;
        lim = DT_PS_LIM_1;
        case (sel)
            DT_PS_1:   lim = DT_PS_LIM_1;
            DT_PS_8:   lim = DT_PS_LIM_8;
            DT_PS_64:  lim = DT_PS_LIM_64;
            default:   lim = DT_PS_LIM_256;
        endcase
        return lim;
    endfunction

endpackage

// ===== verilog/dt_pin_sync.sv
// Two-stage synchroniser with edge detection for a timer pin
`timescale 1ns/10ps
module dt_pin_sync
    import dt_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Edges from the settled stages only
    assign level = s2;
    assign rise  = s2 & ~s3;
    assign fall  = ~s2 & s3;
endmodule

// ===== verilog/dt_prescaler.sv
// Prescaler for one timer: divides input ticks by 1, 8, 64 or 256
`timescale 1ns/10ps
module dt_prescaler
    import dt_pkg::*;
#(
    parameter bit SYNC_OUT = 1'b0
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [1:0] sel,
    output logic            tick_out
);
    logic [7:0] cnt;
    wire  [7:0] lim  = dt_ps_limit(sel);
    wire        term = tick & (cnt == lim);

    // Divider count; clear beats a tick in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt <= DT_RST_PS;
        end else if (clear) begin
            cnt <= DT_RST_PS;
        end else if (tick) begin
            cnt <= term ? DT_RST_PS : cnt + 8'h01;
        end
    end

    // Lower timer retimes the divided tick; upper timer uses it directly
    generate
        if (SYNC_OUT) begin : g_sync
            logic q;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    q <= 1'b0;
                end else begin
                    q <= term & ~clear;
                end
            end
            assign tick_out = q;
        end else begin : g_direct
            assign tick_out = term & ~clear;
        end
    endgenerate

    property p_ps_clear;
        @(posedge clk_sys) disable iff (!resetn)
        clear |=> (cnt == 8'h00);
    endproperty
    a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");
endmodule

// ===== verilog/dt_timer.sv
// Dual 16-bit or single 32-bit timer with register port and ADC trigger
// Notes on behaviour
// - In 32-bit mode lower count is low word, upper count is high word.
// - In 32-bit mode lower control sets everything; the upper control only clears the lower prescaler via a timer_on clear.
// - The 32-bit interrupt uses the upper flag and upper enable.
// - In 16-bit mode both timers run alone, as timer or synchronous counter.
// - Only the lower timer retimes its prescaler output to the system clock.
// - 32-bit timer counts each cycle up to the period, then wraps to zero.
// - Reading the lower count latches the upper count into the holding register.
// - In 32-bit mode write holding then lower count; the held word then loads the upper count.
// - 32-bit counter counts synchronised external rising edges and wraps at period.
// - Idle stops counting when idle_stop is set, else counting continues.
// - Gated mode counts system cycles only while the gate pin is high.
// - The upper gate enable does nothing; gating always uses the lower timer.
// - Gate falling edge ends counting without clearing; software clears the count.
// - A 32-bit period match pulses the ADC trigger output.
// - Prescaler divides the input clock by 1, 8, 64 or 256.
// - In 32-bit mode only the lower prescaler is used.
// - Prescaler clears on count write, timer_on clear, and reset.
// - A switched-off lower timer cannot have its prescaler cleared.
// - Writing a control register leaves the count registers unchanged.
// - In sleep the timer does not count.
// - 32-bit match or gate falling edge sets the upper flag; software clears.
// - Upper interrupt request appears only while the upper enable is set.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module dt_timer
    import dt_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire logic [DT_ADDR_W-1:0] addr,
    input  wire logic [DT_DATA_W-1:0] wr_data,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic      [DT_DATA_W-1:0] rd_data,
    input  wire logic                 lower_timer_clock_pin,
    input  wire logic                 upper_timer_clock_pin,
    input  wire logic                 cpu_idle,
    input  wire logic                 cpu_sleep,
    output logic                      upper_timer_irq,
    output logic                      lower_timer_irq,
    output logic                      adc_trigger
);
    // Registers
    logic     [15:0] lower_timer_count;
    logic     [15:0] upper_timer_count;
    logic     [15:0] upper_count_holding;
    logic     [15:0] lower_period;
    logic     [15:0] upper_period;
    dt_ctrl_t        lower_timer_control;
    dt_ctrl_t        upper_timer_control;
    logic     [15:0] irq_flag_reg_zero;
    logic     [15:0] irq_enable_reg_zero;

    // Address decode: word aligned, index in the upper address bits
    wire       aligned = (addr[1:0] == 2'h0);
    wire [9:0] idx     = addr[DT_ADDR_W-1:2];
    wire sel_lcnt = aligned & (idx == DT_IDX_LOWER_COUNT);
    wire sel_hold = aligned & (idx == DT_IDX_UPPER_HOLD);
    wire sel_ucnt = aligned & (idx == DT_IDX_UPPER_COUNT);
    wire sel_lpr  = aligned & (idx == DT_IDX_LOWER_PERIOD);
    wire sel_upr  = aligned & (idx == DT_IDX_UPPER_PERIOD);
    wire sel_lcon = aligned & (idx == DT_IDX_LOWER_CONTROL);
    wire sel_ucon = aligned & (idx == DT_IDX_UPPER_CONTROL);
    wire sel_flag = aligned & (idx == DT_IDX_IRQ_FLAG);
    wire sel_en   = aligned & (idx == DT_IDX_IRQ_ENABLE);

    wire wr_lcnt = wr_en & sel_lcnt;
    wire wr_hold = wr_en & sel_hold;
    wire wr_ucnt = wr_en & sel_ucnt;
    wire wr_lcon = wr_en & sel_lcon;
    wire wr_ucon = wr_en & sel_ucon;
    wire rd_lcnt = rd_en & sel_lcnt;

    // New control values as they would be stored
    wire dt_ctrl_t lcon_new = dt_ctrl_mask(wr_data, 1'b1);
    wire dt_ctrl_t ucon_new = dt_ctrl_mask(wr_data, 1'b0);

    // Pin synchronisers, lower pin doubles as gate input
    logic [1:0] pin_raw;
    logic [1:0] pin_lvl;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    assign pin_raw = {upper_timer_clock_pin, lower_timer_clock_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            dt_pin_sync u_sync (
                .clk_sys (clk_sys),
                .resetn  (resetn),
                .pin     (pin_raw[gi]),
                .level   (pin_lvl[gi]),
                .rise    (pin_rise[gi]),
                .fall    (pin_fall[gi])
            );
        end
    endgenerate

    // Mode and run conditions
    wire wide = lower_timer_control.wide_mode_select;
    // Gating only from the lower control and only with the system clock
    wire lgate = lower_timer_control.gate_enable & ~lower_timer_control.clock_source_select;
    wire run0 = lower_timer_control.timer_on & ~cpu_sleep
              & ~(cpu_idle & lower_timer_control.idle_stop);
    // Upper timer takes no part in wide mode; only its timer_on clear still reaches the lower prescaler
    wire run1 = ~wide & upper_timer_control.timer_on & ~cpu_sleep
              & ~(cpu_idle & upper_timer_control.idle_stop);

    // Tick sources ahead of the prescalers
    wire src0 = lower_timer_control.clock_source_select ? pin_rise[0]
              : (lgate ? pin_lvl[0] : 1'b1);
    wire src1 = upper_timer_control.clock_source_select ? pin_rise[1] : 1'b1;

    // Prescaler clears; a stopped lower timer keeps its divider state
    wire lcon_off = wr_lcon & lower_timer_control.timer_on & ~lcon_new.timer_on;
    wire ucon_off = wr_ucon & upper_timer_control.timer_on & ~ucon_new.timer_on;
    // An upper timer_on clear must not reach a stopped lower divider either
    wire ps_clr0  = ((wr_lcnt | wr_ucnt | ucon_off) & lower_timer_control.timer_on)
                  | lcon_off;
    wire ps_clr1  = wr_lcnt | wr_ucnt | lcon_off | ucon_off;

    logic [1:0] ps_tick;
    logic [1:0] ps_out;
    logic [1:0] ps_clr;
    logic [3:0] ps_sel;
    assign ps_tick = {src1 & run1, src0 & run0};
    assign ps_clr  = {ps_clr1, ps_clr0};
    assign ps_sel  = {upper_timer_control.prescale_select,
                      lower_timer_control.prescale_select};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_ps
            dt_prescaler #(
                .SYNC_OUT (gi == 0)
            ) u_ps (
                .clk_sys  (clk_sys),
                .resetn   (resetn),
                .tick     (ps_tick[gi]),
                .clear    (ps_clr[gi]),
                .sel      (ps_sel[2*gi +: 2]),
                .tick_out (ps_out[gi])
            );
        end
    endgenerate

    // Count enables; retimed lower tick is gated again so sleep stops it at once
    wire inc0 = ps_out[0] & run0;
    wire inc1 = ps_out[1] & run1;

    // Concatenated count and period
    wire [31:0] cnt32 = {upper_timer_count, lower_timer_count};
    wire [31:0] per32 = {upper_period, lower_period};
    wire m32  = wide & inc0 & (cnt32 == per32);
    wire m_lo = ~wide & inc0 & (lower_timer_count == lower_period);
    wire m_hi = inc1 & (upper_timer_count == upper_period);
    wire [31:0] next_cnt32 = m32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;

    // Gate falling edge ends a gated run without touching the count
    wire gate_fall = lgate & lower_timer_control.timer_on & pin_fall[0];

    // Next counts: software write wins over a tick in the same cycle
    logic [15:0] next_lcnt;
    logic [15:0] next_ucnt;
    assign next_lcnt = wr_lcnt ? wr_data
                     : (wide & inc0) ? next_cnt32[15:0]
                     : inc0 ? (m_lo ? 16'h0000 : lower_timer_count + 16'h0001)
                     : lower_timer_count;
    assign next_ucnt = (wr_lcnt & wide) ? upper_count_holding
                     : wr_ucnt ? wr_data
                     : (wide & inc0) ? next_cnt32[31:16]
                     : inc1 ? (m_hi ? 16'h0000 : upper_timer_count + 16'h0001)
                     : upper_timer_count;

    // Count registers; control writes do not reach them
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lower_timer_count <= DT_RST_COUNT;
            upper_timer_count <= DT_RST_COUNT;
        end else begin
            lower_timer_count <= next_lcnt;
            upper_timer_count <= next_ucnt;
        end
    end

    // Holding register: written by software, loaded on a lower count read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            upper_count_holding <= DT_RST_COUNT;
        end else if (wr_hold) begin
            upper_count_holding <= wr_data;
        end else if (rd_lcnt) begin
            upper_count_holding <= upper_timer_count;
        end
    end

    // Period and control registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lower_period        <= DT_RST_PERIOD;
            upper_period        <= DT_RST_PERIOD;
            lower_timer_control <= dt_ctrl_t'(DT_RST_CONTROL);
            upper_timer_control <= dt_ctrl_t'(DT_RST_CONTROL);
        end else begin
            if (wr_en & sel_lpr) lower_period <= wr_data;
            if (wr_en & sel_upr) upper_period <= wr_data;
            if (wr_lcon) lower_timer_control <= lcon_new;
            if (wr_ucon) upper_timer_control <= ucon_new;
        end
    end

    // Flag sets; in wide mode every event lands on the upper flag
    wire set_u = m32 | m_hi | (wide & gate_fall);
    wire set_l = m_lo | (~wide & gate_fall);
    wire [15:0] flag_set = {8'h00, set_u, set_l, 6'h00};
    wire [15:0] flag_base = (wr_en & sel_flag) ? (wr_data & DT_IRQ_MASK) : irq_flag_reg_zero;
    // Set wins over a software clear in the same cycle
    wire [15:0] next_flag = flag_base | flag_set;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_flag_reg_zero   <= DT_RST_IRQ;
            irq_enable_reg_zero <= DT_RST_IRQ;
        end else begin
            irq_flag_reg_zero <= next_flag;
            if (wr_en & sel_en) irq_enable_reg_zero <= wr_data & DT_IRQ_MASK;
        end
    end

    // Read mux; unmapped or misaligned reads give zero
    wire [15:0] rd_mux = sel_lcnt ? lower_timer_count
                       : sel_hold ? upper_count_holding
                       : sel_ucnt ? upper_timer_count
                       : sel_lpr  ? lower_period
                       : sel_upr  ? upper_period
                       : sel_lcon ? 16'(lower_timer_control)
                       : sel_ucon ? 16'(upper_timer_control)
                       : sel_flag ? irq_flag_reg_zero
                       : sel_en   ? irq_enable_reg_zero
                       : 16'h0000;

    // Registered outputs: read data valid only the cycle after the strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data         <= 16'h0000;
            upper_timer_irq <= 1'b0;
            lower_timer_irq <= 1'b0;
            adc_trigger     <= 1'b0;
        end else begin
            rd_data         <= rd_en ? rd_mux : 16'h0000;
            upper_timer_irq <= irq_flag_reg_zero[DT_BIT_IRQ_UPPER]
                             & irq_enable_reg_zero[DT_BIT_IRQ_UPPER];
            lower_timer_irq <= irq_flag_reg_zero[DT_BIT_IRQ_LOWER]
                             & irq_enable_reg_zero[DT_BIT_IRQ_LOWER];
            adc_trigger     <= m32;
        end
    end

    // Checks
    property p_wrap32;
        @(posedge clk_sys) disable iff (!resetn)
        (m32 && !wr_lcnt && !wr_ucnt) |=> (cnt32 == 32'h0000_0000);
    endproperty
    a_wrap32: assert property (p_wrap32) else $error("32-bit count did not wrap");

    property p_inc32;
        @(posedge clk_sys) disable iff (!resetn)
        (wide && inc0 && !m32 && !wr_lcnt && !wr_ucnt) |=> (cnt32 == $past(cnt32) + 32'h1);
    endproperty
    a_inc32: assert property (p_inc32) else $error("32-bit count did not advance");

    property p_hold_capture;
        @(posedge clk_sys) disable iff (!resetn)
        (rd_lcnt && !wr_hold) |=> (upper_count_holding == $past(upper_timer_count));
    endproperty
    a_hold_capture: assert property (p_hold_capture) else $error("holding not latched");

    property p_coherent_write;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_lcnt && wide) |=> (upper_timer_count == $past(upper_count_holding))
                              && (lower_timer_count == $past(wr_data));
    endproperty
    a_coherent_write: assert property (p_coherent_write) else $error("32-bit write broken");

    property p_ctrl_keeps_count;
        @(posedge clk_sys) disable iff (!resetn)
        ((wr_lcon || wr_ucon) && !inc0 && !inc1) |=> $stable(cnt32);
    endproperty
    a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("count changed");

    property p_sleep_hold;
        @(posedge clk_sys) disable iff (!resetn)
        (cpu_sleep && !wr_lcnt && !wr_ucnt) |=> (cnt32 == $past(cnt32));
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");

    property p_gate_low_hold;
        @(posedge clk_sys) disable iff (!resetn)
        (lgate && !pin_lvl[0] && !ps_out[0] && !wr_lcnt) |=> $stable(lower_timer_count);
    endproperty
    a_gate_low_hold: assert property (p_gate_low_hold) else $error("counted with gate low");

    property p_flag_set;
        @(posedge clk_sys) disable iff (!resetn)
        (m32 || (wide && gate_fall)) |=> irq_flag_reg_zero[DT_BIT_IRQ_UPPER];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("upper flag not set");

    property p_irq_gated;
        @(posedge clk_sys) disable iff (!resetn)
        upper_timer_irq |-> $past(irq_enable_reg_zero[DT_BIT_IRQ_UPPER])
                            && $past(irq_flag_reg_zero[DT_BIT_IRQ_UPPER]);
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq without enable");

    property p_adc;
        @(posedge clk_sys) disable iff (!resetn)
        m32 |=> adc_trigger ##1 !adc_trigger || $past(m32);
    endproperty
    a_adc: assert property (p_adc) else $error("ADC trigger wrong");
endmodule

// ===== verification/dt_timer_tb.sv
// Self-checking bench for the dual 16/32-bit timer through its register port
`timescale 1ns/10ps
module testbench;
    import dt_pkg::*;
    logic                 clk_sys = 1'b0;
    logic                 resetn  = 1'b0;
    logic [DT_ADDR_W-1:0] addr    = '0;
    logic [DT_DATA_W-1:0] wr_data = '0;
    logic                 wr_en   = 1'b0;
    logic                 rd_en   = 1'b0;
    logic [DT_DATA_W-1:0] rd_data;
    logic                 pin_lo  = 1'b0;
    logic                 pin_hi  = 1'b0;
    logic                 cpu_idle = 1'b0;
    logic                 cpu_sleep = 1'b0;
    logic                 upper_timer_irq;
    logic                 lower_timer_irq;
    logic                 adc_trigger;
    int                   fail_count = 0;
    int                   samples_checked = 0;
    int                   cyc = 0;
    int                   lim[4] = '{1, 8, 64, 256};
    logic [15:0]          mdl[int];
    logic [15:0]          a, b, v;
    int                   t0, t1;
    dt_timer i_dt_timer (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .lower_timer_clock_pin(pin_lo),
        .upper_timer_clock_pin(pin_hi), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .upper_timer_irq(upper_timer_irq), .lower_timer_irq(lower_timer_irq),
        .adc_trigger(adc_trigger));
    // 20 MHz system clock and a cycle counter for interval checks
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    // One-cycle write strobe; strobes never overlap since each task spans its own edges
    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1; addr <= {idx, 2'b00}; wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [9:0] idx, output logic [15:0] d);
        @(posedge clk_sys);
        rd_en <= 1'b1; addr <= {idx, 2'b00};
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp, input string name);
        logic [15:0] d;
        rd(idx, d);
        check(name, d, exp);
    endtask
    // Bounded wait for the one-cycle trigger pulse, sampled mid-cycle; the first
    // negedge keeps a pulse already seen out, and catches one that rose at the caller's edge
    task automatic wait_trig(output int t);
        int i;
        @(negedge clk_sys);
        for (i = 0; i < 3000 && adc_trigger !== 1'b1; i++) @(negedge clk_sys);
        check("adc trigger", {15'h0, adc_trigger}, 16'h0001);
        t = cyc;
    endtask
    initial begin
        void'($urandom(45));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values from the register table
        mdl[DT_IDX_LOWER_COUNT] = 16'h0000; mdl[DT_IDX_UPPER_HOLD] = 16'h0000;
        mdl[DT_IDX_UPPER_COUNT] = 16'h0000; mdl[DT_IDX_LOWER_PERIOD] = 16'hffff;
        mdl[DT_IDX_UPPER_PERIOD] = 16'hffff; mdl[DT_IDX_LOWER_CONTROL] = 16'h0000;
        mdl[DT_IDX_UPPER_CONTROL] = 16'h0000;
        foreach (mdl[k]) rdchk(k[9:0], mdl[k], "reset value");
        rdchk(10'h120, 16'h0000, "unmapped read");
        // Random period read-back; control keeps implemented bits only
        v = 16'($urandom); wr(DT_IDX_LOWER_PERIOD, v); rdchk(DT_IDX_LOWER_PERIOD, v, "lper");
        v = 16'($urandom); wr(DT_IDX_UPPER_PERIOD, v); rdchk(DT_IDX_UPPER_PERIOD, v, "uper");
        wr(DT_IDX_LOWER_CONTROL, 16'hffff); rdchk(DT_IDX_LOWER_CONTROL, 16'ha07a, "lctl");
        wr(DT_IDX_UPPER_CONTROL, 16'hffff); rdchk(DT_IDX_UPPER_CONTROL, 16'ha072, "uctl");
        rdchk(DT_IDX_LOWER_COUNT, 16'h0000, "count after ctl write");
        // Coherent 32-bit write then read with the timer off
        wr(DT_IDX_LOWER_CONTROL, 16'h0008);
        a = 16'($urandom); b = 16'($urandom);
        wr(DT_IDX_UPPER_HOLD, a); wr(DT_IDX_LOWER_COUNT, b);
        rdchk(DT_IDX_UPPER_COUNT, a, "upper from hold");
        rdchk(DT_IDX_LOWER_COUNT, b, "lower word");
        wr(DT_IDX_UPPER_COUNT, ~a);
        rdchk(DT_IDX_LOWER_COUNT, b, "lower word");
        rdchk(DT_IDX_UPPER_HOLD, ~a, "hold latched");
        // 32-bit period 3 under every prescale; upper control left at a072 from the all-ones write
        wr(DT_IDX_UPPER_HOLD, 16'h0000); wr(DT_IDX_LOWER_COUNT, 16'h0000);
        wr(DT_IDX_LOWER_PERIOD, 16'h0003); wr(DT_IDX_UPPER_PERIOD, 16'h0000);
        for (int ps = 0; ps < 4; ps++) begin
            wr(DT_IDX_LOWER_CONTROL, 16'h8008 | 16'(ps << 4));
            // First pulse may still come from the old divide ratio
            wait_trig(t0);
            wait_trig(t0);
            wait_trig(t1);
            check("match interval", 16'(t1 - t0), 16'(4 * lim[ps]));
        end
        wr(DT_IDX_LOWER_CONTROL, 16'h0008);
        // Upper flag and gated request
        rd(DT_IDX_IRQ_FLAG, v); check("upper flag", v & 16'h0080, 16'h0080);
        check("irq masked", {15'h0, upper_timer_irq}, 16'h0000);
        wr(DT_IDX_IRQ_ENABLE, 16'h0080); repeat (2) @(posedge clk_sys); #1;
        check("irq enabled", {15'h0, upper_timer_irq}, 16'h0001);
        wr(DT_IDX_IRQ_FLAG, 16'h0000); repeat (2) @(posedge clk_sys); #1;
        check("irq cleared", {15'h0, upper_timer_irq}, 16'h0000);
        // Sleep and idle: reads 12 cycles apart see 12 ticks when running
        wr(DT_IDX_LOWER_PERIOD, 16'hffff); wr(DT_IDX_UPPER_PERIOD, 16'hffff);
        wr(DT_IDX_LOWER_CONTROL, 16'ha008);
        cpu_sleep <= 1'b1; repeat (3) @(posedge clk_sys);
        rd(DT_IDX_LOWER_COUNT, a); repeat (10) @(posedge clk_sys); rd(DT_IDX_LOWER_COUNT, b);
        check("sleep count", b, a);
        cpu_sleep <= 1'b0; cpu_idle <= 1'b1; repeat (3) @(posedge clk_sys);
        rd(DT_IDX_LOWER_COUNT, a); repeat (10) @(posedge clk_sys); rd(DT_IDX_LOWER_COUNT, b);
        check("idle stop count", b, a);
        wr(DT_IDX_LOWER_CONTROL, 16'h8008); repeat (3) @(posedge clk_sys);
        rd(DT_IDX_LOWER_COUNT, a); repeat (10) @(posedge clk_sys); rd(DT_IDX_LOWER_COUNT, b);
        check("idle run count", b - a, 16'd12);
        cpu_idle <= 1'b0;
        // Gated accumulation in wide mode
        wr(DT_IDX_LOWER_CONTROL, 16'h0008); wr(DT_IDX_IRQ_FLAG, 16'h0000);
        wr(DT_IDX_UPPER_HOLD, 16'h0000); wr(DT_IDX_LOWER_COUNT, 16'h0000);
        wr(DT_IDX_LOWER_CONTROL, 16'h8048);
        rd(DT_IDX_LOWER_COUNT, a); repeat (10) @(posedge clk_sys);
        rdchk(DT_IDX_LOWER_COUNT, 16'h0000, "gate low count");
        pin_lo <= 1'b1; repeat (30) @(posedge clk_sys); pin_lo <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd(DT_IDX_LOWER_COUNT, a); repeat (10) @(posedge clk_sys); rd(DT_IDX_LOWER_COUNT, b);
        check("gate held count", b, a);
        check("gate window", {15'h0, a >= 16'd26 && a <= 16'd34}, 16'h0001);
        rd(DT_IDX_IRQ_FLAG, v); check("gate fall flag", v & 16'h0080, 16'h0080);
        // 16-bit mode: each timer counts its own pin edges, periods 4 and 2
        wr(DT_IDX_LOWER_CONTROL, 16'h0002); wr(DT_IDX_IRQ_FLAG, 16'h0000);
        wr(DT_IDX_LOWER_COUNT, 16'h0000); wr(DT_IDX_UPPER_COUNT, 16'h0000);
        wr(DT_IDX_LOWER_PERIOD, 16'h0004); wr(DT_IDX_UPPER_PERIOD, 16'h0002);
        wr(DT_IDX_IRQ_ENABLE, 16'h00c0);
        wr(DT_IDX_UPPER_CONTROL, 16'h8002); wr(DT_IDX_LOWER_CONTROL, 16'h8002);
        repeat (7) begin
            pin_lo <= 1'b1; pin_hi <= 1'b1; repeat (4) @(posedge clk_sys);
            pin_lo <= 1'b0; pin_hi <= 1'b0; repeat (4) @(posedge clk_sys);
        end
        rdchk(DT_IDX_LOWER_COUNT, 16'h0002, "lower pin count");
        rdchk(DT_IDX_UPPER_COUNT, 16'h0001, "upper pin count");
        check("lower irq", {15'h0, lower_timer_irq}, 16'h0001);
        check("upper irq 16", {15'h0, upper_timer_irq}, 16'h0001);
        test_done();
    end
endmodule
